// file: inc/tic_defs.svh
`ifndef TIC_DEFS_SVH
`define TIC_DEFS_SVH

// Register indices; the bus byte address is four times the index.
`define TIC_IDX_CMP_CTRL     8'h1F
`define TIC_IDX_IRQ_FLAGS    8'h2A
`define TIC_IDX_IRQ_MASK     8'h2B
`define TIC_IDX_SYNC_CTRL    8'h2F
`define TIC_IDX_CAPTURE_LO   8'h30
`define TIC_IDX_CAPTURE_HI   8'h31
`define TIC_IDX_INPUT_OFF    8'h32

// Field positions in the timer flag and mask registers.
`define TIC_BIT_OVERFLOW     0
`define TIC_BIT_MATCH_A      1
`define TIC_BIT_MATCH_B      2
`define TIC_BIT_CAPTURE      5

// Field positions in the comparator control and status register.
`define TIC_BIT_CMP_OFF      7
`define TIC_BIT_CMP_RESULT   5
`define TIC_BIT_CMP_FLAG     4
`define TIC_BIT_CMP_IE       3
`define TIC_BIT_CMP_CAPTURE  2

// Field positions in the synchronisation control register.
`define TIC_BIT_SYNC_HOLD    7
`define TIC_BIT_PRESCALE_CLR 0

// Writable bits and reset values.
`define TIC_TIMER_BITS       8'h27
`define TIC_INPUT_OFF_BITS   2'h3
`define TIC_RESET_BYTE       8'h00

// Comparator interrupt modes.
`define TIC_CMP_TOGGLE       2'h0
`define TIC_CMP_FALLING      2'h2
`define TIC_CMP_RISING       2'h3

// Capture noise filter needs this many equal samples.
`define TIC_FILTER_SAMPLES   4

`endif

// file: inc/tic_pkg.sv
package tic_pkg;

	// Bus slave phase, one-hot.
	typedef enum logic [2:0] {
		TIC_BUS_IDLE  = 3'b001,
		TIC_BUS_WRITE = 3'b010,
		TIC_BUS_READ  = 3'b100
	} tic_bus_t;

	// View of the counter core that this block watches.
	typedef struct packed {
		logic [15:0] count_value;
		logic [15:0] compare_a_value;
		logic [15:0] compare_b_value;
		logic [3:0]  waveform_mode;
		logic        timer_tick;
		logic        count_overflow;
		logic        capture_edge_select;
		logic        capture_noise_filter;
	} tic_timer_view_t;

	// Whole state of the block.
	typedef struct packed {
		tic_bus_t    bus;
		logic [7:0]  idx;
		logic        hready;
		logic [31:0] hrdata;
		logic        cmp_sync1;
		logic        cmp_result;
		logic        cmp_prev;
		logic [3:0]  cap_hist;
		logic        cap_filt;
		logic        cap_filt_prev;
		logic        cmp_off;
		logic        cmp_flag;
		logic        cmp_ie;
		logic        cmp_capture;
		logic [1:0]  cmp_mode;
		logic [7:0]  tflags;
		logic [7:0]  tmask;
		logic        sync_hold;
		logic        prescale_clr;
		logic [1:0]  input_off;
		logic [15:0] capture_value;
		logic [7:0]  temp_hi;
		logic [4:0]  irq;
		logic [1:0]  pin_in;
	} tic_state_t;

endpackage : tic_pkg

// file: hw/tic_top.sv
// Notes on behaviour
// [RULE1] A capture event copies the 16-bit counter into the capture register.
// [RULE2] Capture reads as two bytes through a shared 8-bit high-byte latch.
// [RULE3] Mask bits 5,2,1,0 enable sources; interrupt needs enable, flag, global flag.
// [RULE4] Software writes zero to reserved bits of mask, flag, sync registers.
// [RULE5] Capture flag sets on capture, or on reaching TOP when capture is TOP.
// [RULE6] Timer flags clear on vector taken or on writing one; zero keeps.
// [RULE7] Match flags set the timer cycle after counter equals compare value.
// [RULE8] A forced compare strobe never sets a match flag.
// [RULE9] Overflow flag sets on overflow in Normal/CTC, else at mode's point.
// [RULE10] With sync hold set, a written prescaler clear is kept asserted.
// [RULE11] Writing sync hold to zero clears prescaler clear in hardware.
// [RULE12] Prescaler clear resets prescaler and self-clears unless sync hold is set.
// [RULE13] Comparator result bit is synchronised, one to two cycles, read-only.
// [RULE14] Comparator flag sets on selected event; interrupt needs enable and global.
// [RULE15] Comparator flag clears on vector taken or on writing one.
// [RULE16] Comparator mode: 00 toggle, 01 reserved, 10 falling, 11 rising.
// [RULE17] Software disables comparator interrupt before changing mode or power bit.
// [RULE18] Comparator-to-capture bit routes the comparator into the capture front end.
// [RULE19] Comparator register bit 6 always reads zero.
// [RULE20] Input-off bits force the matching pin input bit to read zero.
// [RULE21] When capture value is TOP, the capture pin is disconnected.
// [RULE22] Edge select zero means falling edge, one means rising edge.
// [RULE23] Noise filter passes a change only after four equal samples.
// [RULE24] One request line per source; acknowledge clears the source flag.
`include "tic_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tic_top (
	// Clock and reset.
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	// AHB-Lite slave port.
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic [31:0]                   hrdata,
	output logic                          hresp,
	// Counter core view and global interrupt flag.
	input  wire tic_pkg::tic_timer_view_t timer_view,
	input  wire logic                     global_irq_enable,
	// Capture pin, comparator and its digital pins.
	input  wire logic                     capture_pin,
	input  wire logic                     comparator_raw,
	input  wire logic [1:0]               pin_raw,
	output logic [1:0]                    pin_in,
	output logic                          comparator_power_off,
	// Prescaler control towards the counter core.
	output logic                          prescaler_clear,
	// Interrupt requests and vector acknowledges.
	output logic [4:0]                    irq_req,
	input  wire logic [4:0]               irq_ack
);

	// All state is one packed struct; s_d is its next value.
	tic_pkg::tic_state_t s_q;
	tic_pkg::tic_state_t s_d;
	// Pin levels after the input-off gate.
	logic [1:0]          pin_gated;

	// Top value of the counter for each waveform mode.
	// Mode 13 is reserved and falls to the full range.
	function automatic logic [15:0] top_of(input logic [3:0] mode, input logic [15:0] cap,
		input logic [15:0] cmp_a);
		unique case (mode)
			4'h1, 4'h5:                      top_of = 16'h00FF;
			4'h2, 4'h6:                      top_of = 16'h01FF;
			4'h3, 4'h7:                      top_of = 16'h03FF;
			4'h8, 4'hA, 4'hC, 4'hE:          top_of = cap;
			4'h4, 4'h9, 4'hB, 4'hF:          top_of = cmp_a;
			default:                         top_of = 16'hFFFF;
		endcase
	endfunction : top_of

	// True in the modes that use the capture register as TOP.
	// There the register is a setting, so the input is ignored.
	function automatic logic capture_is_top(input logic [3:0] mode);
		capture_is_top = (mode == 4'h8) || (mode == 4'hA) || (mode == 4'hC) || (mode == 4'hE);
	endfunction : capture_is_top

	// Overflow event point per waveform mode.
	// Dual-slope modes flag at bottom, single-slope at top.
	function automatic logic overflow_event(input tic_pkg::tic_timer_view_t tv,
		input logic [15:0] top);
		unique case (tv.waveform_mode)
			4'h0, 4'h4, 4'hC:                overflow_event = tv.count_overflow;
			4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB:
				overflow_event = tv.timer_tick && (tv.count_value == 16'h0000);
			4'h5, 4'h6, 4'h7, 4'hE, 4'hF:
				overflow_event = tv.timer_tick && (tv.count_value == top);
			default:                         overflow_event = 1'b0;
		endcase
	endfunction : overflow_event

	// Byte value of a register as software reads it.
	// Reserved bits read zero, as constants here or because writes mask them.
	function automatic logic [7:0] read_byte(input tic_pkg::tic_state_t s, input logic [7:0] idx);
		unique case (idx)
			`TIC_IDX_CMP_CTRL:   read_byte = {s.cmp_off, 1'b0, s.cmp_result, s.cmp_flag,
				s.cmp_ie, s.cmp_capture, s.cmp_mode}; // [RULE19] [RULE13]
			`TIC_IDX_IRQ_FLAGS:  read_byte = s.tflags;
			`TIC_IDX_IRQ_MASK:   read_byte = s.tmask;
			`TIC_IDX_SYNC_CTRL:  read_byte = {s.sync_hold, 6'h00, s.prescale_clr};
			`TIC_IDX_CAPTURE_LO: read_byte = s.capture_value[7:0];
			`TIC_IDX_CAPTURE_HI: read_byte = s.temp_hi; // [RULE2]
			`TIC_IDX_INPUT_OFF:  read_byte = {6'h00, s.input_off};
			default:             read_byte = 8'h00;
		endcase
	endfunction : read_byte

	// Digital input gating, one identical cell per comparator pin.
	// A disabled pin reads zero one cycle after the write.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
			assign pin_gated[gi] = pin_raw[gi] & ~s_q.input_off[gi]; // [RULE20]
		end
	endgenerate

	// Next-state logic for the whole block.
	always_comb begin
		// Scratch values, all set at the top of the process.
		logic        take;
		logic        cap_src;
		logic        filt_all_eq;
		logic        cap_edge;
		logic        cap_event;
		logic        cmp_rise;
		logic        cmp_fall;
		logic        cmp_event;
		logic [15:0] top;
		logic [7:0]  tset;
		logic [7:0]  tclr;
		logic [7:0]  wbyte;
		take        = 1'b0;
		cap_src     = 1'b0;
		filt_all_eq = 1'b0;
		cap_edge    = 1'b0;
		cap_event   = 1'b0;
		cmp_rise    = 1'b0;
		cmp_fall    = 1'b0;
		cmp_event   = 1'b0;
		top         = 16'h0000;
		tset        = 8'h00;
		tclr        = 8'h00;
		wbyte       = hwdata[7:0];
		s_d         = s_q;

		// Anything not assigned below keeps its value.

		// Comparator output synchroniser; the first stage feeds only the second.
		// The raw output is asynchronous, so only stage two is used.
		s_d.cmp_sync1  = comparator_raw;
		s_d.cmp_result = s_q.cmp_sync1; // [RULE13]
		s_d.cmp_prev   = s_q.cmp_result;

		// Both edges are decoded; the mode picks which count.
		cmp_rise       = s_q.cmp_result & ~s_q.cmp_prev;
		cmp_fall       = ~s_q.cmp_result & s_q.cmp_prev;
		unique case (s_q.cmp_mode)
			`TIC_CMP_TOGGLE:  cmp_event = cmp_rise | cmp_fall; // [RULE16]
			`TIC_CMP_FALLING: cmp_event = cmp_fall; // [RULE16]
			`TIC_CMP_RISING:  cmp_event = cmp_rise; // [RULE16]
			default:          cmp_event = 1'b0; // Reserved code raises nothing.
		endcase

		// Capture front end: source select, noise filter, edge select.
		// Four agreeing samples cost latency but reject glitches.
		cap_src = s_q.cmp_capture ? s_q.cmp_result : capture_pin; // [RULE18]
		s_d.cap_hist = {s_q.cap_hist[2:0], cap_src};
		filt_all_eq  = (s_q.cap_hist == {`TIC_FILTER_SAMPLES{1'b1}}) ||
			(s_q.cap_hist == {`TIC_FILTER_SAMPLES{1'b0}});

		// With the filter off the source passes straight on.
		if (timer_view.capture_noise_filter) begin
			if (filt_all_eq) begin
				s_d.cap_filt = s_q.cap_hist[0]; // [RULE23]
			end
		end else begin
			s_d.cap_filt = cap_src;
		end

		// The previous filtered value is the edge reference.
		s_d.cap_filt_prev = s_q.cap_filt;
		cap_edge  = timer_view.capture_edge_select ? (s_q.cap_filt & ~s_q.cap_filt_prev)
			: (~s_q.cap_filt & s_q.cap_filt_prev); // [RULE22]
		// In capture-as-TOP modes pin and comparator are cut off.
		cap_event = cap_edge && !capture_is_top(timer_view.waveform_mode); // [RULE21]
		if (cap_event) begin
			s_d.capture_value = timer_view.count_value; // [RULE1]
		end

		// Timer flag set events; forced compares have no path here.
		// One tick per timer clock, so a long match sets once.

		// Overflow at TOP needs the top of the current mode.
		top = top_of(timer_view.waveform_mode, s_q.capture_value, timer_view.compare_a_value);
		tset[`TIC_BIT_MATCH_A] = timer_view.timer_tick &&
			(timer_view.count_value == timer_view.compare_a_value); // [RULE7] [RULE8]
		tset[`TIC_BIT_MATCH_B] = timer_view.timer_tick &&
			(timer_view.count_value == timer_view.compare_b_value); // [RULE7] [RULE8]
		tset[`TIC_BIT_OVERFLOW] = overflow_event(timer_view, top); // [RULE9]
		if (capture_is_top(timer_view.waveform_mode)) begin
			tset[`TIC_BIT_CAPTURE] = timer_view.timer_tick &&
				(timer_view.count_value == s_q.capture_value); // [RULE5]
		end else begin
			tset[`TIC_BIT_CAPTURE] = cap_event; // [RULE5]
		end

		// Vector acknowledges clear their flags.
		// An acknowledge is a one-cycle pulse; it only clears.
		tclr[`TIC_BIT_OVERFLOW] = irq_ack[0]; // [RULE24] [RULE6]
		tclr[`TIC_BIT_MATCH_A]  = irq_ack[1]; // [RULE24] [RULE6]
		tclr[`TIC_BIT_MATCH_B]  = irq_ack[2]; // [RULE24] [RULE6]
		tclr[`TIC_BIT_CAPTURE]  = irq_ack[3]; // [RULE24] [RULE6]

		// Prescaler clear drops after one cycle unless sync hold keeps it.
		// A write below may still override this.
		if (!s_q.sync_hold) begin
			s_d.prescale_clr = 1'b0; // [RULE12]
		end

		// Bus slave: writes land in the data phase with zero wait states.
		// Reads wait one cycle so hrdata comes from a register.
		// Ready rises again after a read's wait state.
		s_d.hready = 1'b1;
		s_d.bus    = tic_pkg::TIC_BUS_IDLE;
		unique case (s_q.bus)
			tic_pkg::TIC_BUS_WRITE: begin
				unique case (s_q.idx)
					`TIC_IDX_CMP_CTRL: begin
						// The result bit is read-only.
						s_d.cmp_off     = wbyte[`TIC_BIT_CMP_OFF];
						s_d.cmp_ie      = wbyte[`TIC_BIT_CMP_IE];
						s_d.cmp_capture = wbyte[`TIC_BIT_CMP_CAPTURE];
						s_d.cmp_mode    = wbyte[1:0];
						if (wbyte[`TIC_BIT_CMP_FLAG]) begin
							s_d.cmp_flag = 1'b0; // [RULE15]
						end
					end
					`TIC_IDX_IRQ_FLAGS: tclr = tclr | (wbyte & `TIC_TIMER_BITS); // [RULE6]
					`TIC_IDX_IRQ_MASK:  s_d.tmask = wbyte & `TIC_TIMER_BITS; // [RULE3]
					`TIC_IDX_SYNC_CTRL: begin
						// Hold keeps a written clear; leaving it drops it.
						s_d.sync_hold    = wbyte[`TIC_BIT_SYNC_HOLD]; // [RULE10]
						s_d.prescale_clr = wbyte[`TIC_BIT_SYNC_HOLD] ?
							(wbyte[`TIC_BIT_PRESCALE_CLR] | s_q.prescale_clr) // [RULE10]
							: wbyte[`TIC_BIT_PRESCALE_CLR]; // [RULE11] [RULE12]
					end
					`TIC_IDX_INPUT_OFF: s_d.input_off = wbyte[1:0] & `TIC_INPUT_OFF_BITS;
					default: ;
				endcase
			end
			tic_pkg::TIC_BUS_READ: begin
				// The read is served one cycle late so that a write just before it is seen.
				// Only the low capture byte loads the latch.
				s_d.hrdata = {24'h000000, read_byte(s_q, s_q.idx)};
				if (s_q.idx == `TIC_IDX_CAPTURE_LO) begin
					s_d.temp_hi = s_q.capture_value[15:8]; // [RULE2]
				end
			end
			default: ;
		endcase

		// Address bits above the map make the access unmapped.
		take = hsel && htrans[1] && hready && s_q.hready;
		if (take) begin
			s_d.idx = (haddr[31:10] == 22'h000000) ? haddr[9:2] : 8'h00;
			if (hwrite) begin
				s_d.bus = tic_pkg::TIC_BUS_WRITE;
			end else begin
				s_d.bus    = tic_pkg::TIC_BUS_READ;
				s_d.hready = 1'b0;
			end
		end

		// Flags: a set in the same cycle as a clear wins.
		// A lost event is worse than a second interrupt.
		s_d.tflags = ((s_q.tflags & ~tclr) | tset) & `TIC_TIMER_BITS;
		if (irq_ack[4]) begin
			s_d.cmp_flag = 1'b0; // [RULE15] [RULE24]
		end
		if (cmp_event) begin
			s_d.cmp_flag = 1'b1; // [RULE14]
		end

		// Requests gated by enable and the global interrupt flag.
		// They are registered, one cycle behind the flag.
		s_d.irq[0] = s_q.tflags[`TIC_BIT_OVERFLOW] & s_q.tmask[`TIC_BIT_OVERFLOW]
			& global_irq_enable; // [RULE3] [RULE24]
		s_d.irq[1] = s_q.tflags[`TIC_BIT_MATCH_A] & s_q.tmask[`TIC_BIT_MATCH_A]
			& global_irq_enable; // [RULE3] [RULE24]
		s_d.irq[2] = s_q.tflags[`TIC_BIT_MATCH_B] & s_q.tmask[`TIC_BIT_MATCH_B]
			& global_irq_enable; // [RULE3] [RULE24]
		s_d.irq[3] = s_q.tflags[`TIC_BIT_CAPTURE] & s_q.tmask[`TIC_BIT_CAPTURE]
			& global_irq_enable; // [RULE3] [RULE24]

		// The comparator enable sits in its own register.
		s_d.irq[4] = s_q.cmp_flag & s_q.cmp_ie & global_irq_enable; // [RULE14]

		// Port input bits after the input-off gate.
		s_d.pin_in = pin_gated;
	end

	// State register; reset loads constants only.
	// The bus must show ready while in reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q        <= '0;
			s_q.bus    <= tic_pkg::TIC_BUS_IDLE;
			s_q.hready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register.
	// The slave never signals an error.
	assign hreadyout            = s_q.hready;
	assign hrdata               = s_q.hrdata;
	assign hresp                = 1'b0 & s_q.hready;
	assign pin_in               = s_q.pin_in;
	assign comparator_power_off = s_q.cmp_off;
	assign prescaler_clear      = s_q.prescale_clr;
	assign irq_req              = s_q.irq;

endmodule : tic_top

`default_nettype wire

// file: verification/tic_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tic_chk (
	// Clock and reset.
	input wire logic                     hclk,
	input wire logic                     hresetn,
	// Bus.
	input wire logic                     hsel,
	input wire logic [1:0]               htrans,
	input wire logic                     hwrite,
	input wire logic                     hready,
	input wire logic                     hreadyout,
	input wire logic [31:0]              hrdata,
	input wire logic                     hresp,
	// Timer, pins and interrupts.
	input wire tic_pkg::tic_timer_view_t timer_view,
	input wire logic                     global_irq_enable,
	input wire logic [1:0]               pin_raw,
	input wire logic [1:0]               pin_in,
	input wire logic [4:0]               irq_req,
	input wire logic [4:0]               irq_ack
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Accepted transfers of either direction.
	sequence read_req;
		hsel && htrans[1] && !hwrite && hready && hreadyout;
	endsequence
	sequence write_req;
		hsel && htrans[1] && hwrite && hready && hreadyout;
	endsequence
	sequence one_wait;
		!hreadyout ##1 hreadyout;
	endsequence

	// A read costs exactly one wait state, a write none.
	read_wait_a: assert property (read_req |=> one_wait)
		else $error("read wait state wrong");
	write_fast_a: assert property (write_req |=> hreadyout)
		else $error("write stalled");
	// Read data must not drift between reads, so byte pairs stay coherent.
	rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
		else $error("read data changed");
	okay_resp_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	// Requests need the global enable one cycle earlier and drop one cycle after it falls.
	irq_global_a: assert property (irq_req != 5'h00 |-> $past(global_irq_enable))
		else $error("request without global enable");
	irq_drop_a: assert property (!global_irq_enable |=> irq_req == 5'h00)
		else $error("request stayed after global off");
	// An acknowledge with no new event removes the request two cycles on.
	ack_clear_a: assert property (irq_ack[0] && !timer_view.timer_tick
		&& !timer_view.count_overflow |-> ##2 !irq_req[0])
		else $error("acknowledge did not clear");
	pin_gate_a: assert property ((pin_in & ~$past(pin_raw)) == 2'h0)
		else $error("pin input not from pin");
endmodule : tic_chk

bind tic_top tic_chk u_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.timer_view(timer_view), .global_irq_enable(global_irq_enable), .pin_raw(pin_raw),
	.pin_in(pin_in), .irq_req(irq_req), .irq_ack(irq_ack)
);
`default_nettype wire

// file: verification/tic_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module tic_cpu_model (
	// Clock and reset.
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Requests in, vector acknowledges out, pacing.
	input  wire logic [4:0] irq_req,
	input  wire logic       ack_on,
	input  wire logic       slow,
	output logic [4:0]      irq_ack
);
	logic [3:0] age_q;

	// Takes the lowest pending vector after a prompt or slow delay; the delay
	// outlasts the two cycles a request needs to fall, so no vector is taken twice.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_ack <= 5'h00;
			age_q   <= 4'h0;
		end else begin
			irq_ack <= 5'h00;
			age_q   <= (ack_on && irq_req != 5'h00) ? age_q + 4'h1 : 4'h0;
			if (age_q == (slow ? 4'h9 : 4'h3)) begin
				irq_ack <= irq_req & (~irq_req + 5'h01);
				age_q   <= 4'h0;
			end
		end
	end
endmodule : tic_cpu_model
`default_nettype wire

// file: verification/timer_irq_capture_sync_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tic_defs.svh"
module timer_irq_capture_sync_tb;
	// Design pins, partner pacing and bookkeeping.
	logic                     hclk, hresetn, hsel, hwrite, hreadyout, hresp, ack_on, slow;
	logic                     global_irq_enable, capture_pin, comparator_raw, cmp_off, psc;
	logic [1:0]               htrans, pin_raw, pin_in;
	logic [4:0]               irq_req, irq_ack;
	logic [31:0]              haddr, hwdata, hrdata, rd;
	tic_pkg::tic_timer_view_t tv;
	int                       err_count, checked, psc_cnt, base;

	tic_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .timer_view(tv),
		.global_irq_enable(global_irq_enable), .capture_pin(capture_pin),
		.comparator_raw(comparator_raw), .pin_raw(pin_raw), .pin_in(pin_in),
		.comparator_power_off(cmp_off), .prescaler_clear(psc), .irq_req(irq_req),
		.irq_ack(irq_ack));
	tic_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .irq_req(irq_req), .ack_on(ack_on),
		.slow(slow), .irq_ack(irq_ack));

	// Clock, and a count of cycles with the prescaler clear high.
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	always @(posedge hclk) psc_cnt <= psc_cnt + int'(psc);

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc

	// One single transfer; holds each phase until the slave is ready.
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr  <= {22'h000000, idx, 2'h0};
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, wd};
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		rd = hrdata;
	endtask : bus

	task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(nm, rd, {24'h000000, exp});
	endtask : rchk

	// One timer clock with a match tick or an overflow.
	task automatic pulse(input logic ovf);
		tv.timer_tick     <= !ovf;
		tv.count_overflow <= ovf;
		cyc(1);
		tv.timer_tick     <= 1'b0;
		tv.count_overflow <= 1'b0;
		cyc(1);
	endtask : pulse

	task automatic t_regs();
		logic [7:0] map [8] = '{`TIC_IDX_CMP_CTRL, `TIC_IDX_IRQ_FLAGS, `TIC_IDX_IRQ_MASK,
			`TIC_IDX_SYNC_CTRL, `TIC_IDX_CAPTURE_LO, `TIC_IDX_CAPTURE_HI, `TIC_IDX_INPUT_OFF, 8'h10};
		foreach (map[i]) rchk("reset", map[i], 8'h00);
		bus(1'b1, `TIC_IDX_IRQ_MASK, 8'h27);
		bus(1'b1, 8'h10, 8'hFF);
		rchk("mask", `TIC_IDX_IRQ_MASK, 8'h27);
		rchk("unmapped", 8'h10, 8'h00);
		bus(1'b1, `TIC_IDX_CMP_CTRL, 8'hC0);
		cyc(1);
		chk("power off", 32'(cmp_off), 32'h1);
		rchk("bit six", `TIC_IDX_CMP_CTRL, 8'h80);
		bus(1'b1, `TIC_IDX_CMP_CTRL, 8'h00);
	endtask : t_regs

	task automatic t_sync();
		base = psc_cnt;
		bus(1'b1, `TIC_IDX_SYNC_CTRL, 8'h01);
		cyc(3);
		chk("clear pulse", psc_cnt - base, 1);
		rchk("self clear", `TIC_IDX_SYNC_CTRL, 8'h00);
		bus(1'b1, `TIC_IDX_SYNC_CTRL, 8'h81);
		cyc(4);
		chk("held", 32'(psc), 32'h1);
		rchk("held reg", `TIC_IDX_SYNC_CTRL, 8'h81);
		bus(1'b1, `TIC_IDX_SYNC_CTRL, 8'h00);
		cyc(2);
		chk("released", 32'(psc), 32'h0);
	endtask : t_sync

	task automatic t_flags();
		global_irq_enable  <= 1'b1;
		tv.compare_a_value <= 16'h0040;
		tv.compare_b_value <= 16'h0041;
		tv.count_value     <= 16'h0040;
		pulse(1'b0);
		rchk("match a", `TIC_IDX_IRQ_FLAGS, 8'h02);
		tv.count_value <= 16'h0041;
		pulse(1'b0);
		pulse(1'b1);
		rchk("b and ovf", `TIC_IDX_IRQ_FLAGS, 8'h07);
		chk("irq all", 32'(irq_req), 32'h7);
		global_irq_enable <= 1'b0;
		cyc(2);
		chk("irq off", 32'(irq_req), 32'h0);
		global_irq_enable <= 1'b1;
		bus(1'b1, `TIC_IDX_IRQ_FLAGS, 8'h00);
		bus(1'b1, `TIC_IDX_IRQ_FLAGS, 8'h02);
		rchk("w1c", `TIC_IDX_IRQ_FLAGS, 8'h05);
		bus(1'b1, `TIC_IDX_IRQ_MASK, 8'h01);
		cyc(2);
		chk("irq mask", 32'(irq_req), 32'h1);
		ack_on <= 1'b1;
		cyc(8);
		ack_on <= 1'b0;
		rchk("ack", `TIC_IDX_IRQ_FLAGS, 8'h04);
		bus(1'b1, `TIC_IDX_IRQ_FLAGS, 8'h27);
		rchk("all clear", `TIC_IDX_IRQ_FLAGS, 8'h00);
	endtask : t_flags

	// Step the pin, then wait past edge detection.
	task automatic cap(input logic [15:0] cnt, input logic pin, input int n);
		tv.count_value <= cnt;
		capture_pin    <= pin;
		cyc(n);
	endtask : cap

	task automatic t_capture();
		tv.capture_edge_select <= 1'b1;
		cap(16'h1234, 1'b1, 6);
		rchk("cap lo", `TIC_IDX_CAPTURE_LO, 8'h34);
		rchk("cap flag", `TIC_IDX_IRQ_FLAGS, 8'h20);
		cap(16'h5555, 1'b0, 6);
		rchk("no fall", `TIC_IDX_CAPTURE_LO, 8'h34);
		cap(16'hABCD, 1'b1, 6);
		rchk("latched hi", `TIC_IDX_CAPTURE_HI, 8'h12);
		rchk("new lo", `TIC_IDX_CAPTURE_LO, 8'hCD);
		rchk("new hi", `TIC_IDX_CAPTURE_HI, 8'hAB);
		tv.capture_noise_filter <= 1'b1;
		tv.capture_edge_select  <= 1'b0;
		cap(16'h2222, 1'b0, 2);
		cap(16'h2222, 1'b1, 8);
		rchk("glitch", `TIC_IDX_CAPTURE_LO, 8'hCD);
		cap(16'h2222, 1'b0, 8);
		rchk("filtered", `TIC_IDX_CAPTURE_LO, 8'h22);
		bus(1'b1, `TIC_IDX_IRQ_FLAGS, 8'h20);
		tv.capture_noise_filter <= 1'b0;
		tv.capture_edge_select  <= 1'b1;
		tv.waveform_mode        <= 4'hC;
		cap(16'h3333, 1'b1, 8);
		rchk("top mode", `TIC_IDX_CAPTURE_LO, 8'h22);
		tv.count_value <= 16'h2222;
		pulse(1'b0);
		rchk("top flag", `TIC_IDX_IRQ_FLAGS, 8'h20);
		tv.waveform_mode <= 4'h0;
		bus(1'b1, `TIC_IDX_IRQ_FLAGS, 8'h20);
	endtask : t_capture

	task automatic t_comparator();
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, `TIC_IDX_CMP_CTRL, 8'(m));
			comparator_raw <= 1'b1;
			cyc(5);
			rchk("rise", `TIC_IDX_CMP_CTRL, {3'h1, 1'(m == 0 || m == 3), 2'h0, 2'(m)});
			bus(1'b1, `TIC_IDX_CMP_CTRL, 8'(m) | 8'h10);
			comparator_raw <= 1'b0;
			cyc(5);
			rchk("fall", `TIC_IDX_CMP_CTRL, {3'h0, 1'(m == 0 || m == 2), 2'h0, 2'(m)});
			bus(1'b1, `TIC_IDX_CMP_CTRL, 8'(m) | 8'h10);
		end
		rchk("no route", `TIC_IDX_IRQ_FLAGS, 8'h00);
		bus(1'b1, `TIC_IDX_CMP_CTRL, 8'h04);
		tv.count_value <= 16'h7777;
		comparator_raw <= 1'b1;
		cyc(6);
		rchk("routed", `TIC_IDX_CAPTURE_LO, 8'h77);
		bus(1'b1, `TIC_IDX_CMP_CTRL, 8'h1C);
		comparator_raw <= 1'b0;
		cyc(6);
		chk("cmp irq", 32'(irq_req), 32'h10);
		slow   <= 1'b1;
		ack_on <= 1'b1;
		cyc(14);
		ack_on <= 1'b0;
		rchk("cmp ack", `TIC_IDX_CMP_CTRL, 8'h0C);
		bus(1'b1, `TIC_IDX_CMP_CTRL, 8'h00);
	endtask : t_comparator

	task automatic t_pins();
		pin_raw <= 2'h3;
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, `TIC_IDX_INPUT_OFF, 8'(k));
			cyc(2);
			chk("pin in", 32'(pin_in), 32'(~k & 3));
			rchk("input off", `TIC_IDX_INPUT_OFF, 8'(k));
		end
	endtask : t_pins

	task automatic results();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results

	// Main sequence; inputs get values at time zero.
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{global_irq_enable, capture_pin, comparator_raw, pin_raw, ack_on, slow} = '0;
		tv = '0;
		cyc(2);
		hresetn <= 1'b1;
		cyc(1);
		t_regs();
		t_sync();
		t_flags();
		t_capture();
		t_comparator();
		t_pins();
		results();
	end

	// The run needs well under a thousand cycles; this cuts a hang short.
	initial begin
		#1000000;
		err_count++;
		results();
	end
endmodule : timer_irq_capture_sync_tb
`default_nettype wire
